// *** csp_pkg.sv ***
// Shared constants and types for the current-sense PWM encoder
package csp_pkg;

  // System clock rate and the averaging slot length
  localparam int unsigned SYS_CLK_HZ     = 200_000_000;
  localparam int unsigned CYCLES_PER_MS  = SYS_CLK_HZ / 1000;
  localparam int unsigned SLOT_MS        = 50;
  localparam int unsigned SLOT_CYCLES    = CYCLES_PER_MS * SLOT_MS;

  // Ramp: 1024 levels, each step split into sub-ticks for the half-step delay
  localparam int unsigned RAMP_W         = 10;
  localparam int unsigned PWM_LEVELS     = 1 << RAMP_W;
  localparam int unsigned SUB_W          = 3;
  localparam int unsigned SUBS_PER_STEP  = 1 << SUB_W;
  localparam int unsigned POS_W          = RAMP_W + SUB_W;
  localparam int unsigned TICKS_PER_SLOT = 1 << POS_W;
  localparam logic [SUB_W-1:0] SUB_HALF  = 3'h4;

  // Modulator samples: one per sub-tick, rounded down to whole cycles
  localparam int unsigned SAMPLE_CYCLES  = SLOT_CYCLES / TICKS_PER_SLOT;
  localparam int unsigned DIV_W          = 16;

  // Position markers within a PWM period
  localparam logic [POS_W-1:0] POS_LAST  = 13'h1FFF;
  localparam logic [POS_W-1:0] POS_CLOSE = 13'h1FFE;
  localparam int unsigned ONES_W         = POS_W + 1;

  // Transfer: code = mid + d * 1024 / (2.2 * samples), d = 2*ones - samples
  localparam logic [RAMP_W-1:0] MID_CODE = 10'h200;
  localparam logic [RAMP_W-1:0] MAX_CODE = 10'h3FF;
  localparam int unsigned GAIN_SHIFT     = 24;
  localparam longint GAIN_NUM            = 10 * PWM_LEVELS;
  localparam longint GAIN_DEN            = 22 * TICKS_PER_SLOT;
  localparam longint GAIN_RECIP =
    (((longint'(1) << GAIN_SHIFT) * GAIN_NUM * 2) / GAIN_DEN + 1) / 2;
  localparam int unsigned PROD_W         = 40;
  localparam logic signed [PROD_W-1:0] ROUND_HALF = 40'sh0000800000;

  // Full-scale options in amperes
  localparam int unsigned FS_LOW_A       = 1;
  localparam int unsigned FS_HIGH_A      = 10;

  // Operating states of the encoder
  typedef enum logic [1:0] {ST_OFF, ST_WARM, ST_RUN} csp_state_t;

endpackage

// *** csp_slot_if.sv ***
// Carrier between the encoder core and its slot filter
`timescale 1ns/10ps
interface csp_slot_if;
  import csp_pkg::*;

  logic              sampleStrobe;
  logic              sampleBit;
  logic              slotClose;
  logic              restart;
  logic              resultValid;
  logic [ONES_W-1:0] onesCount;

  modport filt (
    input  sampleStrobe,
    input  sampleBit,
    input  slotClose,
    input  restart,
    output resultValid,
    output onesCount
  );

  modport ctrl (
    output sampleStrobe,
    output sampleBit,
    output slotClose,
    output restart,
    input  resultValid,
    input  onesCount
  );
endinterface

// *** csp_slot_filter.sv ***
// Decimation filter: counts modulator ones over one averaging slot
`timescale 1ns/10ps
module csp_slot_filter (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  csp_slot_if.filt  slot
);
  import csp_pkg::*;

  logic [ONES_W-1:0] acc_q;
  logic [ONES_W-1:0] acc_d;
  logic [ONES_W-1:0] res_q;
  logic [ONES_W-1:0] res_d;
  logic              val_q;
  logic              val_d;
  logic [ONES_W-1:0] accSum;

  // Boxcar sum; restart drops a partial slot entirely
  always_comb
  begin
    accSum = acc_q + {{(ONES_W-1){1'b0}}, slot.sampleBit};
    acc_d  = acc_q;
    res_d  = res_q;
    val_d  = 1'b0;
    if (slot.restart)
    begin
      acc_d = '0;
    end
    else if (slot.sampleStrobe)
    begin
      if (slot.slotClose)
      begin
        // Slots abut with no overlap
        acc_d = '0;
        res_d = accSum;
        val_d = 1'b1;
      end
      else
      begin
        acc_d = accSum;
      end
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q <= '0;
      res_q <= '0;
      val_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      res_q <= res_d;
      val_q <= val_d;
    end
  end

  assign slot.onesCount   = res_q;
  assign slot.resultValid = val_q;
endmodule

// *** csp_pwm_encoder.sv ***
// Current-sense PWM encoder: slot averaging, scaling and ramp comparator
//
// Overview of operation
// - Filter the one-bit modulator stream into a signed multi-bit current value.
// - Form the PWM output by comparing the value against a digital ramp.
// - Zero average current gives a half-period high time.
// - Positive current raises duty above half, negative lowers it below.
// - Full scale gives 95.5 percent, negative full scale 4.5 percent.
// - Duty equals current over 2.2 times full scale, plus one half.
// - Full scale is a fixed per-variant choice of 1 A or 10 A.
// - Average over abutting 50 ms slots so short surges are smoothed.
// - Duty takes one of 1024 levels, in steps of one 1024th.
// - Code N yields a high time of N plus one half steps.
// - Each period shows the average measured over the slot just before.
// - PWM repeats at about 20 Hz, derived from the internal clock.
`timescale 1ns/10ps
module csp_pwm_encoder #(
  parameter int unsigned FULL_SCALE_A  = csp_pkg::FS_LOW_A,
  parameter int unsigned SAMPLE_CYCLES = csp_pkg::SAMPLE_CYCLES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  input  wire logic                         shutdown_n,
  input  wire logic                         modBit,
  output logic                              modSampleStrobe,
  output logic                              pwmOut,
  output logic [csp_pkg::RAMP_W-1:0]        dutyCode,
  output logic                              rangeHigh
);
  import csp_pkg::*;

  // Synchroniser stages for the two pin inputs: bit 1 shutdown, bit 0 modulator
  logic [1:0]        syncA_q;
  logic [1:0]        syncA_d;
  logic [1:0]        syncB_q;
  logic [1:0]        syncB_d;
  logic              sdLive;
  logic              modLive;

  // Operating state
  csp_state_t        state_q;
  csp_state_t        state_d;

  // Sample divider and period position
  logic [DIV_W-1:0]  div_q;
  logic [DIV_W-1:0]  div_d;
  logic [POS_W-1:0]  pos_q;
  logic [POS_W-1:0]  pos_d;
  logic              tick;
  logic              wrap;
  logic              strobe_q;
  logic              strobe_d;

  // Scaled result waiting for the next period boundary
  logic [RAMP_W-1:0] pend_q;
  logic [RAMP_W-1:0] pend_d;
  logic              pendValid_q;
  logic              pendValid_d;

  // Compare value and output
  logic [RAMP_W-1:0] cmp_q;
  logic [RAMP_W-1:0] cmp_d;
  logic              pwm_q;
  logic              pwm_d;
  logic              range_q;
  logic              range_d;

  // Scaling arithmetic
  logic signed [ONES_W:0]   diff;
  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-1:0] offs;
  logic signed [PROD_W-1:0] codeWide;
  logic [RAMP_W-1:0]        codeSat;

  // Divider terminal count, cut to the divider's DIV_W bits
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_CYCLES - 1);
  localparam logic signed [PROD_W-1:0] GAIN  = PROD_W'(GAIN_RECIP);
  localparam logic signed [ONES_W:0]   NSAMP = (ONES_W+1)'(TICKS_PER_SLOT);

  csp_slot_if slotBus ();

  csp_slot_filter u_filter (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .slot    (slotBus)
  );

  // Two-flop synchronisers; only the second stage is read by logic
  always_comb
  begin
    syncA_d = {shutdown_n, modBit};
    syncB_d = syncA_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA_q <= 2'h0;
      syncB_q <= 2'h0;
    end
    else
    begin
      syncA_q <= syncA_d;
      syncB_q <= syncB_d;
    end
  end

  assign sdLive  = syncB_q[1];
  assign modLive = syncB_q[0];

  // Sample divider and period position; idle and parked while shut down
  always_comb
  begin
    tick     = (state_q != ST_OFF) && (div_q == DIV_LAST);
    wrap     = tick && (pos_q == POS_LAST);
    div_d    = div_q;
    pos_d    = pos_q;
    strobe_d = tick;
    if (state_q == ST_OFF || !sdLive)
    begin
      // Park on the last position so the first tick opens a full slot
      div_d    = '0;
      pos_d    = POS_LAST;
      strobe_d = 1'b0;
    end
    else if (tick)
    begin
      div_d = '0;
      pos_d = pos_q + 1'b1;
    end
    else
    begin
      div_d = div_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q    <= '0;
      pos_q    <= POS_LAST;
      strobe_q <= 1'b0;
    end
    else
    begin
      div_q    <= div_d;
      pos_q    <= pos_d;
      strobe_q <= strobe_d;
    end
  end

  // Feed the slot filter; the slot closes one sample before the wrap
  // so the scaled result is ready when the period turns over
  always_comb
  begin
    slotBus.sampleStrobe = tick;
    slotBus.sampleBit    = modLive;
    slotBus.slotClose    = (pos_q == POS_CLOSE);
    slotBus.restart      = (state_q == ST_OFF) || !sdLive;
  end

  // Signed slot value and scaling to a ramp code
  always_comb
  begin
    diff     = (ONES_W+1)'($signed({1'b0, slotBus.onesCount}) * 2 - NSAMP);
    prod     = PROD_W'(diff) * GAIN;
    offs     = (prod + ROUND_HALF) >>> GAIN_SHIFT;
    codeWide = offs + $signed({{(PROD_W-RAMP_W){1'b0}}, MID_CODE});
    // Saturate; full scale lands near 977 so this only guards overrange
    if (codeWide < 0)
    begin
      codeSat = '0;
    end
    else if (codeWide > $signed({{(PROD_W-RAMP_W){1'b0}}, MAX_CODE}))
    begin
      codeSat = MAX_CODE;
    end
    else
    begin
      codeSat = codeWide[RAMP_W-1:0];
    end
  end

  // Pending code: captured from the filter, consumed at the next wrap
  always_comb
  begin
    pend_d      = pend_q;
    pendValid_d = pendValid_q;
    if (state_q == ST_OFF || !sdLive)
    begin
      pend_d      = MID_CODE;
      pendValid_d = 1'b0;
    end
    else if (slotBus.resultValid)
    begin
      pend_d      = codeSat;
      pendValid_d = 1'b1;
    end
    else if (wrap)
    begin
      pendValid_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_q      <= MID_CODE;
      pendValid_q <= 1'b0;
    end
    else
    begin
      pend_q      <= pend_d;
      pendValid_q <= pendValid_d;
    end
  end

  // State: off while shut down, warm until the first slot is averaged
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_OFF:
      begin
        if (sdLive)
        begin
          state_d = ST_WARM;
        end
      end
      ST_WARM:
      begin
        if (!sdLive)
        begin
          state_d = ST_OFF;
        end
        else if (wrap && pendValid_q)
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!sdLive)
        begin
          state_d = ST_OFF;
        end
      end
      default:
      begin
        state_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_OFF;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Compare value moves only at the wrap, or to midscale at shutdown, so no running period is split
  always_comb
  begin
    cmp_d = cmp_q;
    if (state_q == ST_OFF || !sdLive)
    begin
      cmp_d = MID_CODE;
    end
    else if (wrap && pendValid_q)
    begin
      cmp_d = pend_q;
    end
  end

  // High while position is below N steps plus half a step
  always_comb
  begin
    // Low output while idle or before the first average exists
    pwm_d = (state_d == ST_RUN) &&
            (pos_d < {cmp_d, SUB_HALF});
    // Full-scale choice is fixed per build and only reported, never decoded
    range_d = (FULL_SCALE_A == FS_HIGH_A);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmp_q   <= MID_CODE;
      pwm_q   <= 1'b0;
      range_q <= 1'b0;
    end
    else
    begin
      cmp_q   <= cmp_d;
      pwm_q   <= pwm_d;
      range_q <= range_d;
    end
  end

  // Outputs straight from flops
  assign pwmOut          = pwm_q;
  assign dutyCode        = cmp_q;
  assign modSampleStrobe = strobe_q;
  assign rangeHigh       = range_q;
endmodule

// *** csp_mod_model.sv ***
// Modulator stand-in: one bit per sample strobe, tallies the ones of slot two
`timescale 1ns/10ps
module csp_mod_model (
  input  wire logic        sys_clk,
  input  wire logic        modSampleStrobe,
  output logic             modBit,
  output logic [15:0]      onesSlot
);
  int unsigned idx;
  int          seed;
  logic        nextBit;

  // Slot one is all ones; slot edges forced high so a one-sample skew cannot move the tally
  initial
  begin
    idx      = 0;
    seed     = 32'hCFE4;
    modBit   = 1'b1;
    onesSlot = 16'h0000;
  end

  // Next bit after each strobe, steady until the following tick
  always @(negedge sys_clk)
  begin
    if (modSampleStrobe === 1'b1)
    begin
      idx = idx + 1;
      if (idx <= 8195 || (idx >= 16380 && idx <= 16390))
        nextBit = 1'b1;
      else if (idx < 16380)
        nextBit = (($random(seed) & 3) != 0);
      else
        nextBit = 1'b0;
      if (nextBit && idx >= 8192 && idx <= 16383)
        onesSlot = onesSlot + 16'h0001;
      modBit = nextBit;
    end
  end
endmodule

// *** csp_pwm_encoder_chk.sv ***
// Port checker for the PWM encoder, bound to the top module
`timescale 1ns/10ps
module csp_pwm_encoder_chk #(
  parameter int unsigned FULL_SCALE_A  = 1,
  parameter int unsigned SAMPLE_CYCLES = 4
) (
  input wire logic                       sys_clk,
  input wire logic                       reset_n,
  input wire logic                       shutdown_n,
  input wire logic                       modBit,
  input wire logic                       modSampleStrobe,
  input wire logic                       pwmOut,
  input wire logic [csp_pkg::RAMP_W-1:0] dutyCode,
  input wire logic                       rangeHigh
);
  import csp_pkg::*;
  localparam int unsigned PER_CYC = 8192 * SAMPLE_CYCLES;
  logic [31:0] hiCnt_q;
  logic [31:0] perCnt_q;
  logic [31:0] gapCnt_q;
  logic        runOk_q;
  logic        gapOk_q;

  // Run lengths since the last edge; a shutdown voids the running measure
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hiCnt_q  <= '0;
      perCnt_q <= '0;
      gapCnt_q <= '0;
      runOk_q  <= 1'b0;
      gapOk_q  <= 1'b0;
    end
    else
    begin
      hiCnt_q  <= pwmOut ? hiCnt_q + 1 : '0;
      perCnt_q <= $rose(pwmOut) ? 32'h1 : perCnt_q + 1;
      gapCnt_q <= modSampleStrobe ? 32'h1 : gapCnt_q + 1;
      runOk_q  <= shutdown_n && ($rose(pwmOut) || runOk_q);
      gapOk_q  <= shutdown_n && (modSampleStrobe || gapOk_q);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  strobe_pulse_a: assert property (
    modSampleStrobe |=> !modSampleStrobe) else $error("strobe too long");
  strobe_spacing_a: assert property (
    modSampleStrobe && gapOk_q |-> gapCnt_q == SAMPLE_CYCLES) else $error("strobe gap");
  period_length_a: assert property (
    $rose(pwmOut) && runOk_q |-> perCnt_q == PER_CYC) else $error("period length");
  high_time_a: assert property (
    $fell(pwmOut) && runOk_q |-> hiCnt_q == (32'(dutyCode) * 8 + 4) * SAMPLE_CYCLES)
    else $error("high time");
  code_update_a: assert property (
    !$stable(dutyCode) |-> $rose(pwmOut) || dutyCode == MID_CODE) else $error("code moved");
  wrap_strobe_a: assert property (
    $rose(pwmOut) |-> ##[0:1] modSampleStrobe) else $error("rise off tick");
  shutdown_idle_a: assert property (
    !shutdown_n [*6] |-> !pwmOut && !modSampleStrobe && dutyCode == MID_CODE)
    else $error("not idle");
  warm_quiet_a: assert property (
    $rose(shutdown_n) |-> !pwmOut [*8]) else $error("pulse after restart");
  code_bounds_a: assert property (
    dutyCode >= 10'h02F && dutyCode <= 10'h3D1) else $error("code range");
  range_flag_a: assert property (
    $past(reset_n) |-> rangeHigh == (FULL_SCALE_A == FS_HIGH_A)) else $error("range flag");

  cover property ($rose(pwmOut) && dutyCode == 10'h3D1);
  cover property ($fell(pwmOut) && runOk_q);
  cover property ($fell(shutdown_n));
endmodule

bind csp_pwm_encoder csp_pwm_encoder_chk #(
  .FULL_SCALE_A  (FULL_SCALE_A),
  .SAMPLE_CYCLES (SAMPLE_CYCLES)
) chk (
  .sys_clk         (sys_clk),
  .reset_n         (reset_n),
  .shutdown_n      (shutdown_n),
  .modBit          (modBit),
  .modSampleStrobe (modSampleStrobe),
  .pwmOut          (pwmOut),
  .dutyCode        (dutyCode),
  .rangeHigh       (rangeHigh)
);

// *** testbench.sv ***
// Self-checking bench: slot averaging, duty encoding, period timing, shutdown
`timescale 1ns/10ps
module testbench;
  import csp_pkg::*;
  localparam int unsigned SC  = 4;
  localparam int unsigned PER = 8192 * SC;
  logic              sys_clk;
  logic              reset_n;
  logic              shutdown_n;
  logic              modBit;
  logic              modSampleStrobe;
  logic              pwmOut;
  logic [RAMP_W-1:0] dutyCode;
  logic              rangeHigh;
  logic [15:0]       onesSlot;
  logic [RAMP_W-1:0] expCode;
  int                errors;
  int                checks_done;
  int                hiCnt;
  int                loCnt;
  int                pulses;
  real               ampErr;

  csp_pwm_encoder #(.FULL_SCALE_A(FS_HIGH_A), .SAMPLE_CYCLES(SC)) dut (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .shutdown_n      (shutdown_n),
    .modBit          (modBit),
    .modSampleStrobe (modSampleStrobe),
    .pwmOut          (pwmOut),
    .dutyCode        (dutyCode),
    .rangeHigh       (rangeHigh)
  );

  csp_mod_model model (
    .sys_clk         (sys_clk),
    .modSampleStrobe (modSampleStrobe),
    .modBit          (modBit),
    .onesSlot        (onesSlot)
  );

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checks_done++;
    if (seen !== expd)
    begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Code from the ones tally: offset of d/8192 of full scale over 2.2, around midscale
  function automatic logic [RAMP_W-1:0] exp_code(input int ones);
    real t;
    t = 512.0 + $floor((2.0 * ones - 8192.0) * 10240.0 / 180224.0 + 0.5);
    if (t > 1023.0)
      t = 1023.0;
    return RAMP_W'(int'(t));
  endfunction

  // Receiver view: average n high times, drop the half step, undo the transfer
  function automatic real recover_amps(input int hiSum, input int n);
    real duty;
    duty = real'(hiSum) / (real'(n) * PER) - 1.0 / 2048.0;
    return 2.2 * (duty - 0.5) * FS_HIGH_A;
  endfunction

  // Counts low cycles up to the next rise; a miss ends the run
  task automatic wait_rise(input int limit, output int n);
    n = 0;
    while (pwmOut !== 1'b1 && n < limit)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (pwmOut !== 1'b1)
    begin
      check(pwmOut, 1'b1);
      wrap_up();
    end
  endtask

  // Counts high cycles from a rise
  task automatic measure_high(output int n);
    n = 0;
    while (pwmOut === 1'b1 && n < PER)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  initial
  begin
    sys_clk    = 1'b0;
    reset_n    = 1'b0;
    shutdown_n = 1'b1;
    errors     = 0;
    checks_done = 0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(rangeHigh, 1'b1);
    check(dutyCode, MID_CODE);
    $display("test reset done");
    // Warm period is dark; the first pulse carries the all-ones slot
    wait_rise(3 * PER, loCnt);
    check(loCnt > PER - 8, 1'b1);
    expCode = exp_code(8192);
    check(dutyCode, expCode);
    measure_high(hiCnt);
    check(hiCnt, (8 * expCode + 4) * SC);
    // Recovered current within 1.1 percent of positive full scale
    ampErr = recover_amps(hiCnt, 1) - 1.0 * FS_HIGH_A;
    check((ampErr < 0.011 * FS_HIGH_A) && (ampErr > -0.011 * FS_HIGH_A), 1'b1);
    wait_rise(PER, loCnt);
    check(hiCnt + loCnt, PER);
    $display("test full scale done");
    // Random slot shows one period later
    check(dutyCode, exp_code(onesSlot));
    check(dutyCode > MID_CODE, 1'b1);
    $display("test random slot done");
    // Shutdown mid-pulse, then restart from a cleared state
    repeat (100) @(negedge sys_clk);
    shutdown_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(pwmOut, 1'b0);
    check(dutyCode, MID_CODE);
    shutdown_n = 1'b1;
    pulses = 0;
    hiCnt  = 0;
    repeat (100)
    begin
      @(negedge sys_clk);
      pulses += modSampleStrobe;
      hiCnt  += pwmOut;
    end
    check(hiCnt, 0);
    check(pulses != 0, 1'b1);
    $display("test shutdown done");
    wrap_up();
  end
endmodule
